// File: dv/dfs_monitor.sv
// Concurrent checks on the supervisor ports
`timescale 1ns/100ps
module dfs_monitor (
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire        i_run_cmd,
  input wire [15:0] i_freq_ref,
  input wire        i_overheat,
  input wire        i_derate_en,
  input wire        i_carrier_lower_en,
  input wire [4:0]  i_carrier_max,
  input wire [4:0]  i_carrier_min,
  input wire [6:0]  i_carrier_gain,
  input wire [16:0] i_vbus,
  input wire [6:0]  i_filt_rise,
  input wire [6:0]  i_filt_fall,
  input wire        i_ovp_en,
  input wire [10:0] i_ovp_end_v,
  input wire        i_coast_stop,
  input wire [9:0]  i_primary_accel_time,
  input wire [4:0]  o_carrier,
  input wire        o_carrier_range_error,
  input wire [16:0] o_dc_filter,
  input wire        o_ref_lost,
  input wire        o_running,
  input wire        o_derate_active,
  input wire        o_coast_stop,
  input wire [9:0]  o_accel_time,
  input wire [9:0]  o_decel_time
);
  // ****
  // Port relations
  // ****
  default clocking mon_clk @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_coast_select: assert property (o_coast_stop == (i_ovp_en | i_coast_stop))
    else $error("coast select wrong");
  chk_accel_time: assert property (o_accel_time == (i_ovp_en ? 10'h032 : i_primary_accel_time))
    else $error("accel time wrong");
  chk_decel_high: assert property (i_ovp_en && i_vbus >= i_ovp_end_v * 100 |-> o_decel_time == 10'h3E8)
    else $error("decel time wrong");
  chk_filter_step: assert property ($changed(o_dc_filter) |->
    o_dc_filter == $past(o_dc_filter) + $past(i_filt_rise) ||
    o_dc_filter == $past(o_dc_filter) - $past(i_filt_fall) || o_dc_filter == 17'h00000)
    else $error("filter step wrong");
  chk_carrier_step: assert property ($changed(o_carrier) |->
    o_carrier > $past(o_carrier) || o_carrier == $past(o_carrier) - 5'h01)
    else $error("carrier step wrong");
  chk_range_error: assert property ($rose(o_carrier_range_error) |->
    $past(i_carrier_gain) > 7'h06 && $past(i_carrier_max) < $past(i_carrier_min))
    else $error("range error without cause");
  chk_loss_running: assert property ($rose(o_ref_lost) |-> o_running)
    else $error("loss flagged while idle");
  chk_loss_exit: assert property ($fell(o_ref_lost) |-> !$past(i_run_cmd) || $past(i_freq_ref) != 16'h0000)
    else $error("loss ended without cause");
  chk_derate_cause: assert property ($rose(o_derate_active) |-> $past(i_overheat && i_derate_en) &&
    (!$past(i_carrier_lower_en) || o_carrier == 5'h02 || o_carrier == i_carrier_min))
    else $error("cut without cause");
  cover property ($rose(o_ref_lost));
  cover property ($rose(o_derate_active));
  cover property ($rose(o_carrier_range_error));
endmodule
bind dfs_supervisor dfs_monitor dfs_monitor_i (.*);

// File: dv/dfs_power_stage.sv
// Power stage model: bus voltage and regeneration flag
`timescale 1ns/100ps
module dfs_power_stage (
  input  wire         i_clk,
  input  wire         i_sys_rst,
  input  wire         i_surge,
  input  wire  [16:0] i_base,
  input  wire  [15:0] i_freq,
  output logic [16:0] o_vbus,
  output logic        o_regen
);
  // ****
  // Surge lifts the bus; regeneration is flagged only while the motor turns
  // ****
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_regen <= 1'b0;
      o_vbus  <= 17'h00000;
    end else begin
      o_regen <= i_surge && (i_freq != 16'h0000);
      o_vbus  <= i_base + (i_surge ? 17'h02710 : 17'h00000);
    end
  end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the drive frequency supervisor
`timescale 1ns/100ps
module testbench;
  localparam int T = 20;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_run_cmd = 1'b0, i_overheat = 1'b0, i_derate_en = 1'b0;
  logic        i_carrier_lower_en = 1'b0, i_ovp_en = 1'b0, i_coast_stop = 1'b0, i_loss_sel = 1'b1, surge = 1'b0;
  logic [1:0]  i_ctrl_mode = 2'h0;
  logic [4:0]  i_carrier_set = 5'h08, i_carrier_max = 5'h10, i_carrier_min = 5'h02;
  logic [6:0]  i_carrier_gain = 7'h00, i_filt_rise = 7'h0A, i_filt_fall = 7'h14;
  logic [6:0]  i_start_hold_time = 7'h01, i_stop_hold_time = 7'h01;
  logic [9:0]  i_filt_deadband = 10'h005, i_ovp_gain = 10'h3E8, i_ovp_freq_limit = 10'h0C8, i_loss_level = 10'h1F4;
  logic [9:0]  i_primary_accel_time = 10'h001, i_primary_decel_time = 10'h001;
  logic [9:0]  i_ovp_low_rate_decel_time = 10'h0C8, i_ovp_high_rate_decel_time = 10'h3E8;
  logic [10:0] i_ovp_start_v = 11'h12C, i_ovp_end_v = 11'h1F4;
  logic [15:0] i_freq_ref = 16'h1388, i_nom_freq = 16'h4000, i_max_freq = 16'h1770, i_min_freq = 16'h0064;
  logic [15:0] i_start_hold_freq = 16'h0000, i_stop_hold_freq = 16'h0000;
  logic [16:0] base = 17'h00100;
  wire  [15:0] o_freq;
  wire  [4:0]  o_carrier;
  wire  [16:0] o_dc_filter, i_vbus;
  wire  [9:0]  o_accel_time, o_decel_time;
  wire         o_carrier_range_error, o_ref_lost, o_running, o_derate_active, o_coast_stop, i_regen;
  int          failures = 0, check_count = 0, n;
  // ****
  // Instances and helpers
  // ****
  dfs_supervisor #(.TICK_DIV(T)) dfs_supervisor_i (.*);
  dfs_power_stage dfs_power_stage_i (.i_clk, .i_sys_rst, .i_surge(surge), .i_base(base), .i_freq(o_freq),
    .o_vbus(i_vbus), .o_regen(i_regen));
  initial forever #5 i_clk = ~i_clk;
  task automatic cyc(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task automatic check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic complete_run();
    $display("Totals: %0d checks, %0d mismatches", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic bound(input int b);
    if (n >= b) begin
      check(1'b0, "wait ran out");
      complete_run();
    end
  endtask
  task automatic set_base(input [16:0] v);
    @(posedge i_clk);
    base <= v;
    cyc(2);
  endtask
  task automatic carrier_case(input [4:0] s, mx, mn, input [6:0] g, input [1:0] m, input [4:0] c, input e);
    @(posedge i_clk);
    i_carrier_set <= s;
    i_carrier_max <= mx;
    i_carrier_min <= mn;
    i_carrier_gain <= g;
    i_ctrl_mode <= m;
    cyc(18 * T);
    check(o_carrier === c && o_carrier_range_error === e, "carrier setting");
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_filter();
    cyc(30 * T);
    check(o_dc_filter === 17'h000C8, "filter rise");
    set_base(17'h00000);
    cyc(15 * T);
    check(o_dc_filter === 17'h00028, "filter fall");
    set_base(17'h07918);
    $display("filter test done");
  endtask
  task automatic t_carrier();
    carrier_case(5'h00, 5'h0A, 5'h02, 7'h01, 2'h0, 5'h07, 1'b0);
    carrier_case(5'h00, 5'h09, 5'h02, 7'h01, 2'h0, 5'h07, 1'b0);
    carrier_case(5'h00, 5'h05, 5'h02, 7'h01, 2'h0, 5'h03, 1'b0);
    carrier_case(5'h00, 5'h04, 5'h02, 7'h01, 2'h0, 5'h03, 1'b0);
    carrier_case(5'h00, 5'h04, 5'h08, 7'h01, 2'h0, 5'h04, 1'b0);
    carrier_case(5'h00, 5'h04, 5'h08, 7'h07, 2'h0, 5'h04, 1'b1);
    carrier_case(5'h00, 5'h04, 5'h08, 7'h06, 2'h0, 5'h04, 1'b0);
    carrier_case(5'h00, 5'h0A, 5'h02, 7'h01, 2'h2, 5'h0A, 1'b0);
    carrier_case(5'h0C, 5'h04, 5'h08, 7'h01, 2'h0, 5'h0C, 1'b0);
    $display("carrier test done");
  endtask
  task automatic t_hold();
    @(posedge i_clk);
    i_nom_freq <= 16'h1388;
    i_start_hold_freq <= 16'h01F4;
    i_run_cmd <= 1'b1;
    for (n = 0; n < 30 * T && o_freq !== 16'h01F4; n++) cyc(1);
    bound(30 * T);
    for (n = 0; n < 150 * T && o_freq === 16'h01F4; n++) cyc(1);
    check(n >= 100 * T && n <= 103 * T, "start hold length");
    for (n = 0; n < 100 * T && o_freq !== 16'h1388; n++) cyc(1);
    bound(100 * T);
    $display("hold test done");
  endtask
  task automatic t_loss();
    @(posedge i_clk);
    i_freq_ref <= 16'h0064;
    for (n = 0; n < 30 * T && o_ref_lost !== 1'b1; n++) cyc(1);
    check(n < 30 * T, "loss flag");
    for (n = 0; n < 60 * T && o_freq !== 16'h09C4; n++) cyc(1);
    check(n < 60 * T, "loss level run");
    @(posedge i_clk);
    i_freq_ref <= 16'h0FA0;
    cyc(5 * T);
    check(o_ref_lost === 1'b1, "restore at eighty percent");
    @(posedge i_clk);
    i_freq_ref <= 16'h1194;
    cyc(3 * T);
    check(o_ref_lost === 1'b0, "restore above eighty percent");
    cyc(25 * T);
    @(posedge i_clk);
    i_freq_ref <= 16'h0064;
    cyc(3 * T);
    check(o_ref_lost === 1'b1, "second loss");
    @(posedge i_clk);
    i_run_cmd <= 1'b0;
    cyc(3 * T);
    check(o_ref_lost === 1'b0, "stop ends loss");
    for (n = 0; n < 200 * T && o_running !== 1'b0; n++) cyc(1);
    check(n < 100 * T && o_freq === 16'h0000, "stop without hold");
    $display("loss test done");
  endtask
  task automatic t_derate();
    @(posedge i_clk);
    i_freq_ref <= 16'h1388;
    i_start_hold_freq <= 16'h0000;
    i_overheat <= 1'b1;
    i_run_cmd <= 1'b1;
    cyc(100 * T);
    check(o_freq === 16'h1388 && o_derate_active === 1'b0 && o_carrier === 5'h0C, "no cut when off");
    @(posedge i_clk);
    i_derate_en <= 1'b1;
    for (n = 0; n < 60 * T && o_freq !== 16'h0DAC; n++) cyc(1);
    check(o_derate_active === 1'b1 && n < 60 * T, "cut by thirty percent");
    @(posedge i_clk);
    i_overheat <= 1'b0;
    i_carrier_lower_en <= 1'b1;
    i_carrier_set <= 5'h08;
    cyc(30 * T);
    @(posedge i_clk);
    i_overheat <= 1'b1;
    for (n = 0; n < 20 * T && o_derate_active !== 1'b1; n++) cyc(1);
    check(o_carrier === 5'h02 && n > 5 * T && n < 20 * T, "cut after carrier floor");
    $display("derate test done");
  endtask
  task automatic t_ovp();
    @(posedge i_clk);
    i_overheat <= 1'b0;
    i_derate_en <= 1'b0;
    i_ovp_en <= 1'b1;
    cyc(30 * T);
    set_base(17'h09C40);
    check(o_decel_time === 10'h258 && o_accel_time === 10'h032 && o_coast_stop === 1'b1, "ovp settings");
    set_base(17'h0C350);
    check(o_decel_time === 10'h3E8, "decel at end voltage");
    set_base(17'h04E20);
    check(o_decel_time === 10'h001, "decel below start");
    set_base(17'h07918);
    surge <= 1'b1;
    for (n = 0; n < 300 * T && o_freq !== 16'h1450; n++) cyc(1);
    check(n < 300 * T, "regen boost");
    @(posedge i_clk);
    surge <= 1'b0;
    for (n = 0; n < 300 * T && o_freq !== 16'h1388; n++) cyc(1);
    check(n < 300 * T, "boost decays");
    @(posedge i_clk);
    i_run_cmd <= 1'b0;
    cyc(T + 2);
    check(o_running === 1'b0 && o_freq === 16'h0000, "coast stop");
    $display("ovp test done");
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    cyc(1);
    check(o_carrier === 5'h02 && o_freq === 16'h0000 && o_running === 1'b0, "reset values");
    t_filter();
    t_carrier();
    t_hold();
    t_loss();
    t_derate();
    t_ovp();
    complete_run();
  end
endmodule

// File: rtl/dfs_regs.vh
// Constants for the drive frequency supervisor
`ifndef DFS_REGS_VH
`define DFS_REGS_VH
`define DFS_CLK_NS        10
`define DFS_TICK_NS       1000000
`define DFS_LOSS_WIN_MS   20
`define DFS_TICK_MS       1
`define DFS_TICKS_PER_DS  100
`define DFS_DERATE_PCT    30
`define DFS_LOSS_DROP_DIV 10
`define DFS_RESTORE_NUM   8
`define DFS_RESTORE_DEN   10
`define DFS_SE_GAIN_MAX   6
`define DFS_K_LOW_KHZ     5
`define DFS_K_HIGH_KHZ    10
`define DFS_CARR_FLOOR    2
`define DFS_VC_SHIFT      14
`define DFS_GAIN_DEN      1000
`define DFS_LEVEL_DEN     1000
`define DFS_V_SCALE       100
`define DFS_DB_SCALE      10
`define DFS_OVP_ACC_DFLT  50
`define DFS_OVP_LOW_DFLT  200
`define DFS_OVP_HIGH_DFLT 1000
`endif

// File: rtl/dfs_supervisor.v
// Drive frequency supervisor: derating, carrier, OV prevention, ref loss, hold
//
// Functional notes
// - Overheat derating cuts thirty percent nominal speed
// - With carrier lowering, cut only at minimum
// - Derating off: carrier from setting only; code still lowers it to the floor on overheat when carrier lowering is enabled
// - Variable carrier follows output frequency within limits
// - Vector modes: carrier fixed at maximum limit
// - Coefficient 1, 2, 3 by max limit
// - Gain above 6, max below min: error
// - Minimum above maximum: run at maximum
// - Fixed carrier ignores variable limits and gain
// - Filter rises when bus exceeds rise plus deadband
// - Filter falls when bus below deadband
// - Regeneration adds scaled bus excess to reference
// - Boost decays back to actual reference
// - OVERVOLTAGE_PREVENTION decel rate interpolated between voltages
// - OVERVOLTAGE_PREVENTION enable swaps stop, accel, decel defaults
// - Reference loss: ninety percent drop in 20ms
// - On loss stop or run scaled reference
// - Loss ends on stop or restored reference
// - Start and stop hold frequency and time
// - Hold intervals added outside ramp times
// - Hold skipped below minimum output frequency
`timescale 1ns/100ps
`include "dfs_regs.vh"
module dfs_supervisor #(
  parameter TICK_DIV = `DFS_TICK_NS / `DFS_CLK_NS
) (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_run_cmd,
  input  wire [15:0] i_freq_ref,
  input  wire [15:0] i_nom_freq,
  input  wire [15:0] i_max_freq,
  input  wire [15:0] i_min_freq,
  input  wire [1:0]  i_ctrl_mode,
  input  wire        i_overheat,
  input  wire        i_derate_en,
  input  wire        i_carrier_lower_en,
  input  wire [4:0]  i_carrier_set,
  input  wire [4:0]  i_carrier_max,
  input  wire [4:0]  i_carrier_min,
  input  wire [6:0]  i_carrier_gain,
  input  wire [16:0] i_vbus,
  input  wire [6:0]  i_filt_rise,
  input  wire [6:0]  i_filt_fall,
  input  wire [9:0]  i_filt_deadband,
  input  wire        i_ovp_en,
  input  wire        i_regen,
  input  wire [9:0]  i_ovp_gain,
  input  wire [9:0]  i_ovp_freq_limit,
  input  wire [10:0] i_ovp_start_v,
  input  wire [10:0] i_ovp_end_v,
  input  wire        i_coast_stop,
  input  wire [9:0]  i_primary_accel_time,
  input  wire [9:0]  i_primary_decel_time,
  input  wire [9:0]  i_ovp_low_rate_decel_time,
  input  wire [9:0]  i_ovp_high_rate_decel_time,
  input  wire        i_loss_sel,
  input  wire [9:0]  i_loss_level,
  input  wire [15:0] i_start_hold_freq,
  input  wire [6:0]  i_start_hold_time,
  input  wire [15:0] i_stop_hold_freq,
  input  wire [6:0]  i_stop_hold_time,
  output reg  [15:0] o_freq,
  output reg  [4:0]  o_carrier,
  output reg         o_carrier_range_error,
  output reg  [16:0] o_dc_filter,
  output reg         o_ref_lost,
  output reg         o_running,
  output reg         o_derate_active,
  output wire        o_coast_stop,
  output wire [9:0]  o_accel_time,
  output wire [9:0]  o_decel_time
);
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_SACC  = 7'h02;
  localparam [6:0] ST_SHOLD = 7'h04;
  localparam [6:0] ST_RUN   = 7'h08;
  localparam [6:0] ST_SDEC  = 7'h10;
  localparam [6:0] ST_PHOLD = 7'h20;
  localparam [6:0] ST_FIN   = 7'h40;
  localparam integer LOSS_N = `DFS_LOSS_WIN_MS / `DFS_TICK_MS;

  // ****************************************
  // Control tick divider
  // ****************************************
  reg [31:0] div_cnt;
  reg        tick;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_cnt <= 32'h0;
      tick    <= 1'b0;
    end else begin
      tick <= (div_cnt == TICK_DIV - 1);
      if (div_cnt == TICK_DIV - 1)
        div_cnt <= 32'h0;
      else
        div_cnt <= div_cnt + 32'h1;
    end
  end

  // ****************************************
  // Effective OVERVOLTAGE_PREVENTION settings
  // ****************************************
  assign o_coast_stop = i_ovp_en | i_coast_stop;
  assign o_accel_time = i_ovp_en ? 10'd`DFS_OVP_ACC_DFLT : i_primary_accel_time;
  wire [9:0] low_t  = i_ovp_en ? 10'd`DFS_OVP_LOW_DFLT : i_ovp_low_rate_decel_time;
  wire [9:0] high_t = i_ovp_en ? 10'd`DFS_OVP_HIGH_DFLT : i_ovp_high_rate_decel_time;
  wire [16:0] vbus_v = i_vbus / 17'd`DFS_V_SCALE;
  wire [9:0]  span_t = (high_t >= low_t) ? high_t - low_t : low_t - high_t;
  wire [20:0] quot_t = (span_t * (vbus_v[10:0] - i_ovp_start_v)) / (i_ovp_end_v - i_ovp_start_v);
  reg  [9:0]  dec_t;
  always @* begin
    dec_t = i_primary_decel_time;
    if (i_ovp_en && vbus_v >= {6'h0, i_ovp_start_v}) begin
      if (vbus_v >= {6'h0, i_ovp_end_v} || i_ovp_end_v <= i_ovp_start_v)
        dec_t = high_t;
      else if (high_t >= low_t)
        dec_t = low_t + quot_t[9:0];
      else
        dec_t = low_t - quot_t[9:0];
    end
  end
  assign o_decel_time = dec_t;

  // ****************************************
  // Ramp step sizes
  // ****************************************
  wire [16:0] acc_ticks = o_accel_time * 7'd`DFS_TICKS_PER_DS;
  wire [16:0] dec_ticks = dec_t * 7'd`DFS_TICKS_PER_DS;
  wire [16:0] acc_q  = (acc_ticks == 17'h0) ? {1'b0, i_max_freq} : {1'b0, i_max_freq} / acc_ticks;
  wire [16:0] dec_q  = (dec_ticks == 17'h0) ? {1'b0, i_max_freq} : {1'b0, i_max_freq} / dec_ticks;
  wire [15:0] step_a = (acc_q == 17'h0) ? 16'h1 : acc_q[15:0];
  wire [15:0] step_d = (dec_q == 17'h0) ? 16'h1 : dec_q[15:0];

  // ****************************************
  // Carrier selection
  // ****************************************
  reg        oh_q;
  wire [1:0] k_coef = (i_carrier_max < 5'd`DFS_K_LOW_KHZ) ? 2'd1 :
                      (i_carrier_max < 5'd`DFS_K_HIGH_KHZ) ? 2'd2 : 2'd3;
  wire [15:0] f_gap  = (o_freq < i_nom_freq) ? (i_nom_freq - o_freq) : 16'h0;
  wire [24:0] drop_w = (f_gap * i_carrier_gain * k_coef) >> `DFS_VC_SHIFT;
  wire        var_ok = (i_carrier_set == 5'h0) && (i_carrier_min <= i_carrier_max);
  wire [4:0]  floor_c = var_ok ? i_carrier_min : 5'd`DFS_CARR_FLOOR;
  reg  [4:0]  base_c;
  always @* begin
    if (i_carrier_set != 5'h0)
      base_c = i_carrier_set;
    else if (i_ctrl_mode[1])
      base_c = i_carrier_max;
    else if (i_carrier_min > i_carrier_max)
      base_c = i_carrier_max;
    else if ((i_carrier_max - i_carrier_min) <= drop_w)
      base_c = i_carrier_min;
    else
      base_c = i_carrier_max - drop_w[4:0];
  end
  wire [4:0] tgt_c = (i_carrier_lower_en && oh_q) ? floor_c : base_c;
  wire derate_now = i_derate_en && oh_q &&
                    (!i_carrier_lower_en || o_carrier == floor_c);
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      oh_q                  <= 1'b0;
      o_carrier             <= 5'd`DFS_CARR_FLOOR;
      o_carrier_range_error <= 1'b0;
      o_derate_active       <= 1'b0;
    end else if (tick) begin
      oh_q <= i_overheat;
      o_carrier_range_error <= (i_carrier_gain > 7'd`DFS_SE_GAIN_MAX) &&
                               (i_carrier_max < i_carrier_min);
      o_derate_active <= derate_now;
      if (o_carrier > tgt_c)
        o_carrier <= o_carrier - 5'h1;
      else
        o_carrier <= tgt_c;
    end
  end

  // ****************************************
  // DC bus filter and regen boost
  // ****************************************
  wire [16:0] db_v = i_filt_deadband * 4'd`DFS_DB_SCALE;
  reg  [15:0] boost;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      o_dc_filter <= 17'h0;
    else if (tick) begin
      if ({1'b0, i_vbus} > o_dc_filter + i_filt_rise + db_v)
        o_dc_filter <= o_dc_filter + {10'h0, i_filt_rise};
      else if (i_vbus + db_v < {1'b0, o_dc_filter})
        o_dc_filter <= (o_dc_filter > {10'h0, i_filt_fall}) ?
                       o_dc_filter - {10'h0, i_filt_fall} : 17'h0;
    end
  end

  // ****************************************
  // Reference loss detection
  // ****************************************
  reg [15:0] hist [0:LOSS_N-1];
  reg [4:0]  hptr;
  reg [15:0] last_ref;
  wire [15:0] old_ref = hist[hptr];
  wire loss_hit = (old_ref != 16'h0) &&
                  ({4'h0, i_freq_ref} * 4'd`DFS_LOSS_DROP_DIV <= {4'h0, old_ref});
  wire restored = ({4'h0, i_freq_ref} * 4'd`DFS_RESTORE_DEN >
                   {4'h0, last_ref} * 4'd`DFS_RESTORE_NUM);
  integer hi;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (hi = 0; hi < LOSS_N; hi = hi + 1)
        hist[hi] <= 16'h0;
      hptr       <= 5'h0;
      last_ref   <= 16'h0;
      o_ref_lost <= 1'b0;
    end else if (tick) begin
      hist[hptr] <= i_freq_ref;
      hptr <= (hptr == LOSS_N - 1) ? 5'h0 : hptr + 5'h1;
      if (o_ref_lost) begin
        if (!i_run_cmd || restored)
          o_ref_lost <= 1'b0;
      end else if (loss_hit && o_running) begin
        o_ref_lost <= 1'b1;
        last_ref   <= old_ref;
      end
    end
  end

  // ****************************************
  // Frequency target
  // ****************************************
  wire [25:0] scaled = (last_ref * i_loss_level) / 10'd`DFS_LEVEL_DEN;
  wire [15:0] ref_eff = !o_ref_lost ? i_freq_ref : (i_loss_sel ? scaled[15:0] : 16'h0);
  wire [22:0] cut = (i_nom_freq * 5'd`DFS_DERATE_PCT) / 7'd100;
  wire [15:0] ref_d = !o_derate_active ? ref_eff :
                      (ref_eff > cut[15:0]) ? ref_eff - cut[15:0] : 16'h0;
  wire [16:0] ref_b = ref_d + boost;
  wire [15:0] run_tgt = (ref_b > {1'b0, i_max_freq}) ? i_max_freq : ref_b[15:0];
  wire [16:0] excess = (i_vbus > o_dc_filter) ? i_vbus - o_dc_filter : 17'h0;
  wire [26:0] boost_w = (excess * i_ovp_gain) / 10'd`DFS_GAIN_DEN;
  wire [15:0] boost_c = (boost_w > i_ovp_freq_limit) ? {6'h0, i_ovp_freq_limit} : boost_w[15:0];
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      boost <= 16'h0;
    else if (tick) begin
      if (i_ovp_en && i_regen && o_freq >= ref_d && boost_c >= boost)
        boost <= boost_c;
      else if (boost != 16'h0)
        boost <= boost - 16'h1;
    end
  end

  // ****************************************
  // Run sequence with start and stop hold
  // ****************************************
  reg [6:0]  state;
  reg [13:0] hold_cnt;
  reg [15:0] tgt;
  wire use_shold = i_start_hold_freq >= i_min_freq;
  wire use_phold = i_stop_hold_freq >= i_min_freq;
  always @* begin
    case (state)
      ST_SACC: tgt = i_start_hold_freq;
      ST_SHOLD: tgt = i_start_hold_freq;
      ST_RUN: tgt = run_tgt;
      ST_SDEC: tgt = use_phold ? i_stop_hold_freq : 16'h0;
      ST_PHOLD: tgt = i_stop_hold_freq;
      default: tgt = 16'h0;
    endcase
  end
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state     <= ST_IDLE;
      hold_cnt  <= 14'h0;
      o_freq    <= 16'h0;
      o_running <= 1'b0;
    end else if (tick) begin
      if (state != ST_SHOLD && state != ST_PHOLD) begin
        if (o_freq < tgt)
          o_freq <= (tgt - o_freq > step_a) ? o_freq + step_a : tgt;
        else if (o_freq > tgt)
          o_freq <= (o_freq - tgt > step_d) ? o_freq - step_d : tgt;
      end
      case (state)
        ST_IDLE: begin
          o_freq <= 16'h0;
          if (i_run_cmd) begin
            o_running <= 1'b1;
            state <= use_shold ? ST_SACC : ST_RUN;
          end
        end
        ST_SACC: begin
          hold_cnt <= 14'h0;
          if (o_freq == tgt)
            state <= ST_SHOLD;
        end
        ST_SHOLD: begin
          hold_cnt <= hold_cnt + 14'h1;
          if (hold_cnt >= i_start_hold_time * 7'd`DFS_TICKS_PER_DS)
            state <= ST_RUN;
        end
        ST_RUN: begin
          if (!i_run_cmd) begin
            if (o_coast_stop) begin
              o_freq    <= 16'h0;
              o_running <= 1'b0;
              state     <= ST_IDLE;
            end else
              state <= ST_SDEC;
          end
        end
        ST_SDEC: begin
          hold_cnt <= 14'h0;
          if (o_freq == tgt)
            state <= use_phold ? ST_PHOLD : ST_FIN;
        end
        ST_PHOLD: begin
          hold_cnt <= hold_cnt + 14'h1;
          if (hold_cnt >= i_stop_hold_time * 7'd`DFS_TICKS_PER_DS)
            state <= ST_FIN;
        end
        ST_FIN: begin
          if (o_freq == 16'h0) begin
            o_running <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
